/* File: src/sfse_defines.svh */
// constants for the set-all-ones and sleep execution block
`ifndef SFSE_DEFINES_SVH
`define SFSE_DEFINES_SVH

// ----------------------------------------------------------------
// opcode patterns
// ----------------------------------------------------------------
`define SFSE_SET_ALL_ONES_OP_MASK 16'hFE00
`define SFSE_SET_ALL_ONES_OP_MATCH 16'h6800
`define SFSE_SLEEP_CODE 16'h0003
`define SFSE_ACC_BIT 8
`define SFSE_FILE_MSB 7
`define SFSE_ALL_ONES 8'hFF

// ----------------------------------------------------------------
// access bank split
// ----------------------------------------------------------------
`define SFSE_ACC_SPLIT 8'h80
`define SFSE_ACC_LOW_BANK 4'h0
`define SFSE_ACC_HIGH_BANK 4'hF

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SFSE_REG_CTRL 8'h00
`define SFSE_REG_STATUS 8'h04
`define SFSE_REG_INT_STAT 8'h08
`define SFSE_REG_INT_MASK 8'h0C

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define SFSE_CTRL_EN_BIT 0
`define SFSE_CTRL_RST 1'h1
`define SFSE_PD_RST 1'h1
`define SFSE_TO_RST 1'h1
`define SFSE_INT_W 4
`define SFSE_INT_SET_ALL_ONES_OP 0
`define SFSE_INT_SLEEP 1
`define SFSE_INT_WAKE_WDT 2
`define SFSE_INT_WAKE_OTHER 3
`define SFSE_INT_RST 4'h0
`define SFSE_RD_ZERO 32'h0000_0000

`endif

/* File: src/sfse_pkg.sv */
// types shared by the set-all-ones and sleep execution block
package sfse_pkg;

    typedef enum logic [1:0]
    {
        SFSE_Q1 = 2'b00,
        SFSE_Q2 = 2'b01,
        SFSE_Q3 = 2'b10,
        SFSE_Q4 = 2'b11
    } sfse_phase_e;

    typedef enum logic [1:0]
    {
        SFSE_OP_NONE = 2'b00,
        SFSE_OP_SET_ALL_ONES_OP = 2'b01,
        SFSE_OP_SLEEP = 2'b10
    } sfse_op_e;

    // data memory write port
    typedef struct packed
    {
        logic we;
        logic [11:0] addr;
        logic [7:0] data;
    } sfse_dmem_wr_s;

    // status flags towards the core
    typedef struct packed
    {
        logic powerdown_flag;
        logic timeout_flag;
    } sfse_flags_s;

endpackage

/* File: src/sfse_phase_gen.sv */
// four-phase instruction cycle sequencer, parked at Q1 while asleep
`timescale 1ns/1ns
module sfse_phase_gen
    import sfse_pkg::*;
(
    input wire logic clk, // core clock
    input wire logic srst, // sync reset, high
    input wire logic hold, // oscillator stopped
    output sfse_phase_e phase // current phase
);

    sfse_phase_e phase_ff;
    sfse_phase_e nxt_phase;

    always_comb
    begin
        unique case (phase_ff)
            SFSE_Q1: nxt_phase = hold ? SFSE_Q1 : SFSE_Q2;
            SFSE_Q2: nxt_phase = SFSE_Q3;
            SFSE_Q3: nxt_phase = SFSE_Q4;
            SFSE_Q4: nxt_phase = SFSE_Q1;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            phase_ff <= SFSE_Q1;
        else
            phase_ff <= nxt_phase;
    end

    assign phase = phase_ff;

endmodule

/* File: src/sfse_bank_resolve.sv */
// resolves an 8-bit file address to a full data memory address
`timescale 1ns/1ns
`include "sfse_defines.svh"
module sfse_bank_resolve
#(
    parameter int BANK_W = 4,
    parameter int FILE_W = 8
)
(
    input wire logic [FILE_W-1:0] file_addr, // address field
    input wire logic access_bit, // 0 = access bank
    input wire logic [BANK_W-1:0] bank_sel, // bank select register
    output logic [BANK_W+FILE_W-1:0] mem_addr // resolved address
);

    initial
    begin
        if (BANK_W != 4 || FILE_W != 8)
            $error("sfse_bank_resolve: only 4-bit bank and 8-bit file supported");
    end

    logic [BANK_W-1:0] bank;

    always_comb
    begin
        if (access_bit)
            bank = bank_sel;
        else if (file_addr < `SFSE_ACC_SPLIT)
            bank = `SFSE_ACC_LOW_BANK;
        else
            bank = `SFSE_ACC_HIGH_BANK;
        mem_addr = {bank, file_addr};
    end

endmodule

/* File: src/sfse_exec.sv */
// decode and execution of the set-all-ones and sleep instructions
`timescale 1ns/1ns
`include "sfse_defines.svh"

// Notes on behaviour
// - set-all-ones opcode: 0110 100a, 8-bit file address below the access bit
// - set-all-ones writes FFh to the register, status flags untouched
// - access bit 0 resolves through the access bank, bank select ignored
// - access bit 1 (default) resolves through the bank select register
// - fixed sleep opcode enters low power with oscillator halted
// - sleep clears the power-down flag
// - sleep sets the time-out flag
// - sleep resets watchdog counter and postscaler to zero
// - wake-up by watchdog time-out clears the time-out flag
module sfse_exec
    import sfse_pkg::*;
#(
    parameter int BANK_W = 4,
    parameter int FILE_W = 8,
    parameter int ADDR_W = 8,
    parameter int SYNC_N = 2
)
(
    input wire logic SYS_CLK, // core clock, 100 MHz
    input wire logic SRST, // sync reset, high
    input wire logic [15:0] INSTR_WORD, // fetched instruction
    input wire logic INSTR_VALID, // instruction present for Q1
    input wire logic [BANK_W-1:0] BANK_SEL, // bank select register
    input wire logic WAKE_REQ, // wake-up request pin
    input wire logic WAKE_BY_WDT, // wake cause is watchdog time-out
    output sfse_dmem_wr_s DMEM_WR, // data memory write
    output sfse_flags_s FLAGS, // power-down and time-out flags
    output logic WDT_CLEAR, // clears watchdog and postscaler
    output logic OSC_RUN, // oscillator running
    output logic ASLEEP, // low-power state
    output sfse_phase_e PHASE, // current instruction phase
    input wire logic [ADDR_W-1:0] REG_ADDR, // register byte address
    input wire logic [31:0] REG_WDATA, // register write data
    input wire logic REG_WR, // write strobe
    input wire logic REG_RD, // read strobe
    output logic [31:0] REG_RDATA, // read data, cycle after strobe
    output logic IRQ // interrupt, level
);

    // ----------------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------------
    initial
    begin
        if (BANK_W + FILE_W != 12)
            $error("sfse_exec: data memory address must be 12 bits");
        if (SYNC_N < 2)
            $error("sfse_exec: synchroniser needs at least two stages");
        if (ADDR_W < 4)
            $error("sfse_exec: register address too narrow");
    end

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    sfse_phase_e phase;
    sfse_op_e op_ff;
    sfse_op_e nxt_op;
    logic [15:0] instr_ff;
    logic [SYNC_N-1:0] wake_sync_ff;
    logic [SYNC_N-1:0] wdt_sync_ff;
    logic wake_req_s;
    logic wake_wdt_s;
    logic [BANK_W+FILE_W-1:0] res_addr;
    logic ctrl_en_ff;
    logic asleep_ff;
    logic powerdown_ff;
    logic timeout_ff;
    logic wdt_clear_ff;
    logic osc_run_ff;
    logic dmem_we_ff;
    logic [BANK_W+FILE_W-1:0] dmem_addr_ff;
    logic [`SFSE_INT_W-1:0] int_stat_ff;
    logic [`SFSE_INT_W-1:0] int_mask_ff;
    logic [`SFSE_INT_W-1:0] nxt_int_stat;
    logic [`SFSE_INT_W-1:0] int_set;
    logic [`SFSE_INT_W-1:0] int_clr;
    logic irq_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic act_edge;
    logic do_set_all_ones_op;
    logic do_sleep;
    logic wake_now;

    // ----------------------------------------------------------------
    // phase sequencer
    // ----------------------------------------------------------------
    sfse_phase_gen u_phase
    (
        .clk(SYS_CLK),
        .srst(SRST),
        .hold(asleep_ff),
        .phase(phase)
    );

    // ----------------------------------------------------------------
    // wake-up input synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
        begin
            wake_sync_ff <= '0;
            wdt_sync_ff <= '0;
        end
        else
        begin
            wake_sync_ff <= {wake_sync_ff[SYNC_N-2:0], WAKE_REQ};
            wdt_sync_ff <= {wdt_sync_ff[SYNC_N-2:0], WAKE_BY_WDT};
        end
    end

    assign wake_req_s = wake_sync_ff[SYNC_N-1];
    assign wake_wdt_s = wdt_sync_ff[SYNC_N-1];

    // ----------------------------------------------------------------
    // Q1 decode
    // ----------------------------------------------------------------
    always_comb
    begin
        if ((INSTR_WORD & `SFSE_SET_ALL_ONES_OP_MASK) == `SFSE_SET_ALL_ONES_OP_MATCH)
            nxt_op = SFSE_OP_SET_ALL_ONES_OP;
        else if (INSTR_WORD == `SFSE_SLEEP_CODE)
            nxt_op = SFSE_OP_SLEEP;
        else
            nxt_op = SFSE_OP_NONE;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
        begin
            op_ff <= SFSE_OP_NONE;
            instr_ff <= 16'h0000;
        end
        else if (phase == SFSE_Q1 && !asleep_ff)
        begin
            if (INSTR_VALID && ctrl_en_ff)
            begin
                op_ff <= nxt_op;
                instr_ff <= INSTR_WORD;
            end
            else
            begin
                op_ff <= SFSE_OP_NONE;
            end
        end
    end

    // ----------------------------------------------------------------
    // address resolution
    // ----------------------------------------------------------------
    sfse_bank_resolve #(.BANK_W(BANK_W), .FILE_W(FILE_W)) u_bank
    (
        .file_addr(instr_ff[`SFSE_FILE_MSB:0]),
        .access_bit(instr_ff[`SFSE_ACC_BIT]),
        .bank_sel(BANK_SEL),
        .mem_addr(res_addr)
    );

    // the edge entering Q4 makes the outputs stand during Q4
    assign act_edge = (phase == SFSE_Q3);
    assign do_set_all_ones_op = act_edge && op_ff == SFSE_OP_SET_ALL_ONES_OP;
    assign do_sleep = act_edge && op_ff == SFSE_OP_SLEEP;
    assign wake_now = asleep_ff && wake_req_s;

    // ----------------------------------------------------------------
    // data memory write
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
        begin
            dmem_we_ff <= 1'b0;
            dmem_addr_ff <= '0;
        end
        else
        begin
            dmem_we_ff <= do_set_all_ones_op;
            if (do_set_all_ones_op)
                dmem_addr_ff <= res_addr;
        end
    end

    // ----------------------------------------------------------------
    // sleep state and oscillator
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
        begin
            asleep_ff <= 1'b0;
            osc_run_ff <= 1'b1;
        end
        else if (do_sleep)
        begin
            asleep_ff <= 1'b1;
            osc_run_ff <= 1'b0;
        end
        else if (wake_now)
        begin
            asleep_ff <= 1'b0;
            osc_run_ff <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // watchdog clear
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
            wdt_clear_ff <= 1'b0;
        else
            wdt_clear_ff <= do_sleep;
    end

    // ----------------------------------------------------------------
    // power-down and time-out flags, untouched by set-all-ones
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
        begin
            powerdown_ff <= `SFSE_PD_RST;
            timeout_ff <= `SFSE_TO_RST;
        end
        else if (do_sleep)
        begin
            powerdown_ff <= 1'b0;
            timeout_ff <= 1'b1;
        end
        else if (wake_now && wake_wdt_s)
        begin
            timeout_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
            ctrl_en_ff <= `SFSE_CTRL_RST;
        else if (REG_WR && REG_ADDR == ADDR_W'(`SFSE_REG_CTRL))
            ctrl_en_ff <= REG_WDATA[`SFSE_CTRL_EN_BIT];
    end

    // ----------------------------------------------------------------
    // interrupt status and mask
    // ----------------------------------------------------------------
    always_comb
    begin
        int_set = '0;
        int_set[`SFSE_INT_SET_ALL_ONES_OP] = do_set_all_ones_op;
        int_set[`SFSE_INT_SLEEP] = do_sleep;
        int_set[`SFSE_INT_WAKE_WDT] = wake_now && wake_wdt_s;
        int_set[`SFSE_INT_WAKE_OTHER] = wake_now && !wake_wdt_s;
        int_clr = '0;
        if (REG_RD && REG_ADDR == ADDR_W'(`SFSE_REG_INT_STAT))
            int_clr = int_stat_ff;
        // a new event in the clearing cycle survives
        nxt_int_stat = (int_stat_ff & ~int_clr) | int_set;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
            int_stat_ff <= `SFSE_INT_RST;
        else
            int_stat_ff <= nxt_int_stat;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
            int_mask_ff <= `SFSE_INT_RST;
        else if (REG_WR && REG_ADDR == ADDR_W'(`SFSE_REG_INT_MASK))
            int_mask_ff <= REG_WDATA[`SFSE_INT_W-1:0];
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
            irq_ff <= 1'b0;
        else if (REG_WR && REG_ADDR == ADDR_W'(`SFSE_REG_INT_MASK))
            irq_ff <= |(nxt_int_stat & REG_WDATA[`SFSE_INT_W-1:0]);
        else
            irq_ff <= |(nxt_int_stat & int_mask_ff);
    end

    // ----------------------------------------------------------------
    // register read
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_rdata = `SFSE_RD_ZERO;
        if (REG_RD)
        begin
            if (REG_ADDR == ADDR_W'(`SFSE_REG_CTRL))
                nxt_rdata = {31'h0000_0000, ctrl_en_ff};
            else if (REG_ADDR == ADDR_W'(`SFSE_REG_STATUS))
                nxt_rdata = {26'h000_0000, phase, osc_run_ff, asleep_ff,
                    timeout_ff, powerdown_ff};
            else if (REG_ADDR == ADDR_W'(`SFSE_REG_INT_STAT))
                nxt_rdata = {28'h000_0000, int_stat_ff};
            else if (REG_ADDR == ADDR_W'(`SFSE_REG_INT_MASK))
                nxt_rdata = {28'h000_0000, int_mask_ff};
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
            rdata_ff <= `SFSE_RD_ZERO;
        else
            rdata_ff <= nxt_rdata;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign DMEM_WR.we = dmem_we_ff;
    assign DMEM_WR.addr = dmem_addr_ff;
    assign DMEM_WR.data = `SFSE_ALL_ONES;
    assign FLAGS.powerdown_flag = powerdown_ff;
    assign FLAGS.timeout_flag = timeout_ff;
    assign WDT_CLEAR = wdt_clear_ff;
    assign OSC_RUN = osc_run_ff;
    assign ASLEEP = asleep_ff;
    assign PHASE = phase;
    assign REG_RDATA = rdata_ff;
    assign IRQ = irq_ff;

endmodule

/* File: bench/sfse_mem_model.sv */
// data memory model on the far side of the execution block
`timescale 1ns/1ns
module sfse_mem_model
    import sfse_pkg::*;
(
    input wire logic clk, // core clock
    input sfse_dmem_wr_s wr, // write port from the block
    input wire logic [11:0] rd_addr, // bench peek address
    output logic [7:0] rd_data // stored byte
);
    logic [7:0] mem_ff [4096];
    // ----
    // storage
    // ----
    // preload a non-ones pattern so a missed write shows up
    initial
    begin
        for (int i = 0; i < 4096; i++)
        begin
            mem_ff[i] = 8'h5A;
        end
    end
    always @(posedge clk)
    begin
        if (wr.we)
        begin
            mem_ff[wr.addr] <= wr.data;
        end
    end
    assign rd_data = mem_ff[rd_addr];
endmodule

/* File: bench/sfse_exec_properties.sv */
// concurrent checks on the execution block ports
`timescale 1ns/1ns
module sfse_exec_props
    import sfse_pkg::*;
#(
    parameter int BANK_W = 4
)
(
    input wire logic SYS_CLK, // core clock
    input wire logic SRST, // sync reset
    input wire logic [15:0] INSTR_WORD, // instruction
    input wire logic INSTR_VALID, // instruction valid
    input wire logic [BANK_W-1:0] BANK_SEL, // bank select
    input wire logic WAKE_BY_WDT, // wake cause
    input sfse_dmem_wr_s DMEM_WR, // memory write
    input sfse_flags_s FLAGS, // status flags
    input wire logic WDT_CLEAR, // watchdog clear
    input wire logic OSC_RUN, // oscillator running
    input wire logic ASLEEP, // low power
    input sfse_phase_e PHASE // phase
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SRST);
    logic [7:0] file_f;
    logic at_q1;
    logic is_set_all_ones_op;
    assign file_f = INSTR_WORD[7:0];
    assign at_q1 = PHASE == SFSE_Q1 && INSTR_VALID && !ASLEEP;
    assign is_set_all_ones_op = (INSTR_WORD & 16'hFE00) == 16'h6800;
    // ----
    // sequences
    // ----
    sequence set_all_ones_op_req;
        at_q1 && is_set_all_ones_op;
    endsequence
    sequence sleep_req;
        at_q1 && INSTR_WORD == 16'h0003;
    endsequence
    sequence sleep_done;
        ASLEEP && !OSC_RUN && WDT_CLEAR && PHASE == SFSE_Q4;
    endsequence
    // ----
    // assertions
    // ----
    set_all_ones_op_take_a: assert property (set_all_ones_op_req |-> ##3 DMEM_WR.we)
        else $error("set-all-ones write missing");
    other_op_a: assert property (PHASE == SFSE_Q1 && INSTR_VALID && !is_set_all_ones_op
        |-> ##3 !DMEM_WR.we) else $error("write from another opcode");
    set_all_ones_op_data_a: assert property (DMEM_WR.we |-> DMEM_WR.data == 8'hFF && $stable(FLAGS))
        else $error("bad write data or flags moved");
    we_phase_a: assert property (DMEM_WR.we |-> PHASE == SFSE_Q4)
        else $error("write outside fourth phase");
    bank_sel_a: assert property (set_all_ones_op_req ##0 INSTR_WORD[8]
        |-> ##3 DMEM_WR.addr == {$past(BANK_SEL), $past(file_f, 3)})
        else $error("bank select address wrong");
    access_a: assert property (set_all_ones_op_req ##0 !INSTR_WORD[8]
        |-> ##3 DMEM_WR.addr == {($past(file_f, 3) >= 8'h80) ? 4'hF : 4'h0, $past(file_f, 3)})
        else $error("access bank address wrong");
    sleep_entry_a: assert property (sleep_req |-> ##3 sleep_done
        ##0 (!FLAGS.powerdown_flag && FLAGS.timeout_flag)) else $error("sleep entry wrong");
    wdt_clear_a: assert property (WDT_CLEAR |-> $rose(ASLEEP) ##1 !WDT_CLEAR)
        else $error("watchdog clear not a sleep pulse");
    asleep_quiet_a: assert property (ASLEEP |-> !DMEM_WR.we && !OSC_RUN)
        else $error("activity while asleep");
    wake_wdt_a: assert property ($fell(ASLEEP) && $past(WAKE_BY_WDT, 2)
        |-> !FLAGS.timeout_flag) else $error("timeout flag kept on watchdog wake");
endmodule

bind sfse_exec sfse_exec_props #(.BANK_W(BANK_W)) sfse_exec_props_inst (
    .SYS_CLK(SYS_CLK), .SRST(SRST), .INSTR_WORD(INSTR_WORD), .INSTR_VALID(INSTR_VALID),
    .BANK_SEL(BANK_SEL), .WAKE_BY_WDT(WAKE_BY_WDT), .DMEM_WR(DMEM_WR), .FLAGS(FLAGS),
    .WDT_CLEAR(WDT_CLEAR), .OSC_RUN(OSC_RUN), .ASLEEP(ASLEEP), .PHASE(PHASE)
);

/* File: bench/sfse_exec_tb.sv */
// self-checking bench for the execution block
`timescale 1ns/1ns
module sfse_exec_tb;
    import sfse_pkg::*;
    logic SYS_CLK = 1'b0;
    logic SRST = 1'b1;
    logic [15:0] INSTR_WORD = 16'h0000;
    logic INSTR_VALID = 1'b0;
    logic [3:0] BANK_SEL = 4'h0;
    logic WAKE_REQ = 1'b0;
    logic WAKE_BY_WDT = 1'b0;
    logic [7:0] REG_ADDR = 8'h00;
    logic [31:0] REG_WDATA = 32'h0000_0000;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    sfse_dmem_wr_s DMEM_WR;
    sfse_flags_s FLAGS;
    sfse_phase_e PHASE;
    logic WDT_CLEAR, OSC_RUN, ASLEEP, IRQ;
    logic [31:0] REG_RDATA;
    logic [11:0] peek_addr = 12'h000;
    logic [7:0] peek_data;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    sfse_exec sfse_exec_inst (.SYS_CLK(SYS_CLK), .SRST(SRST), .INSTR_WORD(INSTR_WORD),
        .INSTR_VALID(INSTR_VALID), .BANK_SEL(BANK_SEL), .WAKE_REQ(WAKE_REQ),
        .WAKE_BY_WDT(WAKE_BY_WDT), .DMEM_WR(DMEM_WR), .FLAGS(FLAGS), .WDT_CLEAR(WDT_CLEAR),
        .OSC_RUN(OSC_RUN), .ASLEEP(ASLEEP), .PHASE(PHASE), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .IRQ(IRQ));
    sfse_mem_model sfse_mem_model_inst (.clk(SYS_CLK), .wr(DMEM_WR), .rd_addr(peek_addr),
        .rd_data(peek_data));
    always #5 SYS_CLK = ~SYS_CLK;
    // ----
    // helpers
    // ----
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge SYS_CLK)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_total++;
            $display("ERROR t=%0t run hung", $time);
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge SYS_CLK);
        REG_WR <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge SYS_CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge SYS_CLK);
        REG_RD <= 1'b0;
        #1;
        d = REG_RDATA;
    endtask
    // presents one word for the next Q1 edge, returns settled in its Q4
    task automatic issue(input logic [15:0] w, input logic [3:0] b);
        int n = 0;
        #1;
        while (PHASE !== SFSE_Q4 && n < 8)
        begin
            @(posedge SYS_CLK);
            #1;
            n++;
        end
        @(posedge SYS_CLK);
        INSTR_WORD <= w;
        INSTR_VALID <= 1'b1;
        BANK_SEL <= b;
        @(posedge SYS_CLK);
        INSTR_VALID <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        #1;
    endtask
    // ----
    // scenarios
    // ----
    task automatic test_set_all_ones_op();
        logic [15:0] w [5] = '{16'h69A5, 16'h6825, 16'h68C0, 16'h69FF, 16'h6A00};
        logic [3:0] b [5] = '{4'h3, 4'h3, 4'h3, 4'hF, 4'h3};
        logic [11:0] ea [5];
        for (int i = 0; i < 5; i++)
        begin
            issue(w[i], b[i]);
            ea[i] = w[i][8] ? {b[i], w[i][7:0]} : {w[i][7] ? 4'hF : 4'h0, w[i][7:0]};
            chk(32'(DMEM_WR.we), (i < 4) ? 32'h1 : 32'h0, "write strobe");
            chk(32'(FLAGS), 32'h3, "flags kept");
            if (i < 4)
            begin
                chk(32'(DMEM_WR.addr), 32'(ea[i]), "address");
                chk(32'(DMEM_WR.data), 32'h0000_00FF, "data");
            end
        end
        @(posedge SYS_CLK);
        for (int i = 0; i < 5; i++)
        begin
            peek_addr = (i < 4) ? ea[i] : 12'h000;
            #1;
            chk(32'(peek_data), (i < 4) ? 32'h0000_00FF : 32'h0000_005A, "memory");
        end
        $display("test_set_all_ones_op done");
    endtask
    task automatic test_irq();
        logic [31:0] d;
        issue(16'h6910, 4'h2);
        repeat (2) @(posedge SYS_CLK);
        #1;
        chk(32'(IRQ), 32'h0, "irq masked");
        reg_wr(8'h0C, 32'h0000_0001);
        reg_rd(8'h0C, d);
        chk(d, 32'h0000_0001, "mask readback");
        reg_rd(8'h04, d);
        chk(d & 32'h0000_000F, 32'h0000_000B, "status idle");
        chk(32'(IRQ), 32'h1, "irq raised");
        reg_rd(8'h08, d);
        chk(d & 32'h0000_0001, 32'h0000_0001, "set_all_ones_op event");
        repeat (2) @(posedge SYS_CLK);
        #1;
        chk(32'(IRQ), 32'h0, "irq cleared");
        reg_rd(8'h40, d);
        chk(d, 32'h0000_0000, "unmapped read");
        $display("test_irq done");
    endtask
    task automatic test_sleep(input logic wdt);
        int n = 0;
        logic [31:0] d;
        issue(16'h0003, 4'h0);
        chk(32'({ASLEEP, OSC_RUN, WDT_CLEAR}), 32'h5, "sleep entry");
        chk(32'(FLAGS), 32'h1, "sleep flags");
        @(posedge SYS_CLK);
        INSTR_WORD <= 16'h69A5;
        INSTR_VALID <= 1'b1;
        #1;
        chk(32'(WDT_CLEAR), 32'h0, "clear pulse");
        repeat (8) @(posedge SYS_CLK);
        #1;
        chk(32'({ASLEEP, DMEM_WR.we}), 32'h2, "fetch ignored asleep");
        @(posedge SYS_CLK);
        INSTR_VALID <= 1'b0;
        WAKE_REQ <= 1'b1;
        WAKE_BY_WDT <= wdt;
        #1;
        while (ASLEEP !== 1'b0 && n < 8)
        begin
            @(posedge SYS_CLK);
            #1;
            n++;
        end
        chk(32'({ASLEEP, OSC_RUN}), 32'h1, "woken");
        chk(32'(FLAGS.timeout_flag), 32'(!wdt), "timeout after wake");
        @(posedge SYS_CLK);
        WAKE_REQ <= 1'b0;
        WAKE_BY_WDT <= 1'b0;
        reg_rd(8'h08, d);
        chk(d, wdt ? 32'h0000_0006 : 32'h0000_000A, "sleep events");
        $display("test_sleep done");
    endtask
    initial
    begin
        repeat (6) @(posedge SYS_CLK);
        SRST <= 1'b0;
        test_set_all_ones_op();
        test_irq();
        test_sleep(1'b0);
        test_sleep(1'b1);
        test_sleep(1'b0);
        complete_run();
    end
endmodule
